// file: core/trc_consts.vh
`ifndef TRC_CONSTS_VH
`define TRC_CONSTS_VH
// Register byte offsets (low 12 address bits)
`define TRC_REG_CTRL 12'h000
`define TRC_REG_TARGET 12'h004
`define TRC_REG_STATUS 12'h008
`define TRC_REG_COUNTER 12'h00c
`define TRC_REG_ENTRY0 12'h010
`define TRC_REG_ENTRY1 12'h014
`define TRC_REG_MASK0 12'h020
`define TRC_REG_MASK1 12'h024
`define TRC_REG_ACTION0 12'h040
`define TRC_ACTION_BLOCK_MASK 12'hfc0
`define TRC_ACTION_WORDS 4'h9
// Update control fields
`define TRC_CTRL_CLEAR_BIT 1
`define TRC_CTRL_SHOT_BIT 2
`define TRC_CTRL_ADDR_LSB 3
`define TRC_CTRL_ADDR_MSB 15
// Status fields
`define TRC_STAT_BUSY_BIT 0
`define TRC_STAT_RANGE_BIT 1
// Targets
`define TRC_TGT_ROUTE 2'h0
`define TRC_TGT_EGRESS 2'h1
`define TRC_TGT_CLASS 2'h2
// Geometry
`define TRC_RP_DEPTH 1024
`define TRC_RP_LAST 10'h3ff
`define TRC_RP_LIMIT 13'h0400
`define TRC_RP_EW 36
`define TRC_RP_AW 70
`define TRC_ER_RULES 10'h200
`define TRC_ER_LAST 9'h1ff
`define TRC_ER_DEFAULTS 4'hb
`define TRC_ER_DEPTH 523
`define TRC_ER_LIMIT 13'h020b
`define TRC_ER_EW 30
`define TRC_ER_AW 285
`define TRC_CLS_LO 13'h0400
`define TRC_CLS_HI 13'h0bff
// Type-group code of a single-address route entry
`define TRC_TG_X1 1'h1
// Cycles an update keeps the busy flag up
`define TRC_UPDATE_CYCLES 3'h4
`endif

// file: core/trc_tcam_core.v
`timescale 1ns/100ps
`default_nettype none
`include "trc_consts.vh"
module trc_tcam_core (
    input wire clk_sys_i, // System clock, 25 MHz
    input wire rstn_i, // Async reset, active low
    input wire hsel_i, // AHB slave select
    input wire [31:0] haddr_i, // AHB address
    input wire [1:0] htrans_i, // AHB transfer type
    input wire hwrite_i, // AHB write
    input wire [2:0] hsize_i, // AHB size, word only
    input wire [31:0] hwdata_i, // AHB write data
    input wire hready_i, // AHB bus ready
    output wire hreadyout_o, // AHB slave ready
    output wire hresp_o, // AHB response, always OKAY
    output reg [31:0] hrdata_o, // AHB read data
    input wire rp_block_en_i, // Resource block assigned to route lookup
    input wire cls_map_i, // Blocks two and three mapped to classification
    input wire rp_key_valid_i, // Route key strobe
    input wire [34:0] rp_key_i, // Route key
    output wire rp_ready_o, // Route lookup idle
    output reg rp_done_o, // Route result pulse
    output reg rp_hit_o, // Route entry matched
    output reg [9:0] rp_addr_o, // Matching route address
    output reg [69:0] rp_action_o, // Route action
    input wire er_key_valid_i, // Egress key strobe
    input wire [29:0] er_key_i, // Egress key
    input wire [3:0] er_default_i, // Default rule for a miss
    output wire er_ready_o, // Egress lookup idle
    output reg er_done_o, // Egress result pulse
    output reg er_hit_o, // Egress entry matched
    output reg [9:0] er_addr_o, // Hit or default address
    output reg [284:0] er_action_o, // Egress action
    output reg cls_wr_o, // Classification copy pulse
    output reg [12:0] cls_wr_addr_o, // Classification copy address
    output wire busy_o // Update busy flag
);

    function tmatch;
        input [35:0] e;
        input [35:0] m;
        input [35:0] k;
        begin
            tmatch = ((e ^ k) & ~m) == 36'h0;
        end
    endfunction

    integer i;

    // Bus slave
    reg wr_q;
    reg rd_q;
    reg rd_rdy;
    reg [11:0] a_q;
    reg [31:0] rd_val;
    wire acc = hsel_i && hready_i && htrans_i[1];
    wire wr_en = wr_q && hready_i;
    wire act_sel = ((a_q & `TRC_ACTION_BLOCK_MASK) == `TRC_REG_ACTION0) && (a_q[5:2] < `TRC_ACTION_WORDS);

    // Reads take one wait state so that a write just before is always seen
    assign hreadyout_o = !(rd_q && !rd_rdy);
    assign hresp_o = 1'b0;

    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            rd_rdy <= 1'b0;
            a_q <= 12'h000;
            hrdata_o <= 32'h0;
        end
        else if (hready_i)
        begin
            wr_q <= acc && hwrite_i;
            rd_q <= acc && !hwrite_i;
            rd_rdy <= 1'b0;
            a_q <= haddr_i[11:0];
        end
        else if (rd_q)
        begin
            rd_rdy <= 1'b1;
            hrdata_o <= rd_val;
        end
    end

    // Cache and update engine state
    reg [31:0] ent_w [0:1];
    reg [31:0] msk_w [0:1];
    reg [31:0] act_w [0:8];
    reg cache_cnt;
    reg [1:0] target;
    reg busy;
    reg [2:0] ucnt;
    reg [12:0] uaddr;
    reg [1:0] utgt;
    reg range_err;

    wire ctrl_wr = wr_en && (a_q == `TRC_REG_CTRL) && !busy;
    wire clr = ctrl_wr && hwdata_i[`TRC_CTRL_CLEAR_BIT];
    wire shot = ctrl_wr && hwdata_i[`TRC_CTRL_SHOT_BIT];
    wire commit = busy && (ucnt == 3'h0);
    wire [63:0] ent_cat = {ent_w[1], ent_w[0]};
    wire [63:0] msk_cat = {msk_w[1], msk_w[0]};
    wire [287:0] act_cat = {act_w[8], act_w[7], act_w[6], act_w[5], act_w[4], act_w[3], act_w[2], act_w[1], act_w[0]};
    // no block means route updates have nowhere to land
    wire rp_ok = (utgt == `TRC_TGT_ROUTE) && rp_block_en_i && (uaddr < `TRC_RP_LIMIT);
    wire er_ok = (utgt == `TRC_TGT_EGRESS) && (uaddr < `TRC_ER_LIMIT);
    // classification range only while blocks are mapped
    wire cls_ok = (utgt == `TRC_TGT_CLASS) && cls_map_i && (uaddr >= `TRC_CLS_LO) && (uaddr <= `TRC_CLS_HI);

    assign busy_o = busy;

    always @*
    begin
        rd_val = 32'h0;
        if (act_sel)
            rd_val = act_w[a_q[5:2]];
        else
            case (a_q)
                `TRC_REG_CTRL:
                begin
                    rd_val[`TRC_CTRL_ADDR_MSB:`TRC_CTRL_ADDR_LSB] = uaddr;
                    rd_val[`TRC_CTRL_SHOT_BIT] = busy;
                end
                `TRC_REG_TARGET: rd_val[1:0] = target;
                `TRC_REG_STATUS:
                begin
                    rd_val[`TRC_STAT_BUSY_BIT] = busy;
                    rd_val[`TRC_STAT_RANGE_BIT] = range_err;
                end
                `TRC_REG_COUNTER: rd_val[0] = cache_cnt;
                `TRC_REG_ENTRY0: rd_val = ent_w[0];
                `TRC_REG_ENTRY1: rd_val = ent_w[1];
                `TRC_REG_MASK0: rd_val = msk_w[0];
                `TRC_REG_MASK1: rd_val = msk_w[1];
                default: rd_val = 32'h0;
            endcase
    end

    // Cache writes are dropped while an update runs, so the copy stays coherent
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                ent_w[i] <= 32'h0;
                msk_w[i] <= 32'h0;
            end
            for (i = 0; i < 9; i = i + 1)
                act_w[i] <= 32'h0;
            cache_cnt <= 1'b0;
            target <= `TRC_TGT_ROUTE;
        end
        else if (clr)
        begin
            for (i = 0; i < 2; i = i + 1)
            begin
                ent_w[i] <= 32'h0;
                msk_w[i] <= 32'h0;
            end
            for (i = 0; i < 9; i = i + 1)
                act_w[i] <= 32'h0;
            cache_cnt <= 1'b0;
        end
        else if (wr_en && !busy)
        begin
            if (act_sel)
                act_w[a_q[5:2]] <= hwdata_i;
            else
                case (a_q)
                    `TRC_REG_TARGET: target <= hwdata_i[1:0];
                    `TRC_REG_COUNTER: cache_cnt <= hwdata_i[0];
                    `TRC_REG_ENTRY0: ent_w[0] <= hwdata_i;
                    `TRC_REG_ENTRY1: ent_w[1] <= hwdata_i;
                    `TRC_REG_MASK0: msk_w[0] <= hwdata_i;
                    `TRC_REG_MASK1: msk_w[1] <= hwdata_i;
                    default: ;
                endcase
        end
    end

    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            busy <= 1'b0;
            ucnt <= 3'h0;
            uaddr <= 13'h0;
            utgt <= `TRC_TGT_ROUTE;
            range_err <= 1'b0;
            cls_wr_o <= 1'b0;
            cls_wr_addr_o <= 13'h0;
        end
        else
        begin
            cls_wr_o <= commit && cls_ok;
            if (commit && cls_ok)
                cls_wr_addr_o <= uaddr;
            // busy up on shot, down after the copy
            if (shot)
            begin
                busy <= 1'b1;
                ucnt <= `TRC_UPDATE_CYCLES - 3'h1;
                uaddr <= hwdata_i[`TRC_CTRL_ADDR_MSB:`TRC_CTRL_ADDR_LSB];
                utgt <= target;
            end
            else if (commit)
                busy <= 1'b0;
            else if (busy)
                ucnt <= ucnt - 3'h1;
            // Set wins over the clear
            if (commit && !(rp_ok || er_ok || cls_ok))
                range_err <= 1'b1;
            else if (wr_en && (a_q == `TRC_REG_STATUS) && hwdata_i[`TRC_STAT_RANGE_BIT])
                range_err <= 1'b0;
        end
    end

    // Lookup memories: storage only, validity kept in reset flops
    reg [35:0] rp_ent [0:`TRC_RP_DEPTH-1];
    reg [35:0] rp_msk [0:`TRC_RP_DEPTH-1];
    reg [69:0] rp_act [0:`TRC_RP_DEPTH-1];
    reg [29:0] er_ent [0:`TRC_ER_DEPTH-1];
    reg [29:0] er_msk [0:`TRC_ER_DEPTH-1];
    reg [284:0] er_act [0:`TRC_ER_DEPTH-1];
    reg [`TRC_RP_DEPTH-1:0] rp_vld;
    reg [`TRC_RP_DEPTH-1:0] rp_cnt;
    reg [`TRC_ER_DEPTH-1:0] er_vld;
    reg [`TRC_ER_DEPTH-1:0] er_wrn;
    reg [`TRC_ER_DEPTH-1:0] er_cnt;

    // route widths taken from cache words
    // offsets stored exactly as software laid them out
    // bits above the stored widths are dropped, hence zero
    always @(posedge clk_sys_i)
    begin
        if (commit && rp_ok)
        begin
            rp_ent[uaddr[9:0]] <= ent_cat[35:0];
            rp_msk[uaddr[9:0]] <= msk_cat[35:0];
            rp_act[uaddr[9:0]] <= act_cat[69:0];
        end
        if (commit && er_ok)
        begin
            er_ent[uaddr[9:0]] <= ent_cat[29:0];
            er_msk[uaddr[9:0]] <= msk_cat[29:0];
            er_act[uaddr[9:0]] <= act_cat[284:0];
        end
    end

    // Route lookup scan: one address a cycle, lowest matching address wins
    reg rp_scan;
    reg [9:0] rp_idx;
    reg [35:0] rp_kq;
    wire rp_m = rp_vld[rp_idx] && tmatch(rp_ent[rp_idx], rp_msk[rp_idx], rp_kq);
    assign rp_ready_o = !rp_scan;

    // Egress lookup scan over the 512 rule addresses
    reg er_scan;
    reg [8:0] er_idx;
    reg [29:0] er_kq;
    reg [3:0] er_dq;
    wire er_m = er_vld[er_idx] && tmatch({6'h0, er_ent[er_idx]}, {6'h0, er_msk[er_idx]}, {6'h0, er_kq});
    wire [9:0] er_daddr = `TRC_ER_RULES + {6'h0, er_dq};
    assign er_ready_o = !er_scan;

    // Valid flags and hit counters; an update to an address overrides a same-cycle hit
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rp_vld <= {`TRC_RP_DEPTH{1'b0}};
            rp_cnt <= {`TRC_RP_DEPTH{1'b0}};
            er_vld <= {`TRC_ER_DEPTH{1'b0}};
            er_wrn <= {`TRC_ER_DEPTH{1'b0}};
            er_cnt <= {`TRC_ER_DEPTH{1'b0}};
        end
        else
        begin
            if (rp_scan && rp_block_en_i && rp_m)
                rp_cnt[rp_idx] <= 1'b1;
            if (er_scan && er_m)
                er_cnt[er_idx] <= 1'b1;
            else if (er_scan && (er_idx == `TRC_ER_LAST))
                er_cnt[er_daddr] <= 1'b1;
            // rule resident once the copy lands
            if (commit && rp_ok)
            begin
                // all-zero entry and mask is match-off
                rp_vld[uaddr[9:0]] <= |{ent_cat[35:0], msk_cat[35:0]};
                rp_cnt[uaddr[9:0]] <= cache_cnt;
            end
            if (commit && er_ok)
            begin
                er_vld[uaddr[9:0]] <= (uaddr < {3'h0, `TRC_ER_RULES}) && (|{ent_cat[29:0], msk_cat[29:0]});
                er_wrn[uaddr[9:0]] <= 1'b1;
                er_cnt[uaddr[9:0]] <= cache_cnt;
            end
        end
    end

    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rp_scan <= 1'b0;
            rp_idx <= 10'h0;
            rp_kq <= 36'h0;
            rp_done_o <= 1'b0;
            rp_hit_o <= 1'b0;
            rp_addr_o <= 10'h0;
            rp_action_o <= 70'h0;
        end
        else
        begin
            rp_done_o <= 1'b0;
            if (!rp_scan)
            begin
                if (rp_key_valid_i)
                begin
                    // no block assigned gives an immediate miss
                    if (!rp_block_en_i)
                    begin
                        rp_done_o <= 1'b1;
                        rp_hit_o <= 1'b0;
                        rp_action_o <= 70'h0;
                    end
                    else
                        rp_scan <= 1'b1;
                    rp_idx <= 10'h0;
                    // key carries the X1 type-group code at bit 0
                    rp_kq <= {rp_key_i, `TRC_TG_X1};
                end
            end
            // end of memory without a match is a miss
            else if (!rp_block_en_i || rp_m || (rp_idx == `TRC_RP_LAST))
            begin
                rp_scan <= 1'b0;
                rp_done_o <= 1'b1;
                rp_hit_o <= rp_block_en_i && rp_m;
                rp_addr_o <= rp_idx;
                rp_action_o <= (rp_block_en_i && rp_m) ? rp_act[rp_idx] : 70'h0;
            end
            else
                rp_idx <= rp_idx + 10'h1;
        end
    end

    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            er_scan <= 1'b0;
            er_idx <= 9'h0;
            er_kq <= 30'h0;
            er_dq <= 4'h0;
            er_done_o <= 1'b0;
            er_hit_o <= 1'b0;
            er_addr_o <= 10'h0;
            er_action_o <= 285'h0;
        end
        else
        begin
            er_done_o <= 1'b0;
            if (!er_scan)
            begin
                if (er_key_valid_i)
                begin
                    er_scan <= 1'b1;
                    er_idx <= 9'h0;
                    er_kq <= er_key_i;
                    // default chosen with the key, out-of-range clamps to last
                    er_dq <= (er_default_i < `TRC_ER_DEFAULTS) ? er_default_i : (`TRC_ER_DEFAULTS - 4'h1);
                end
            end
            else if (er_m)
            begin
                er_scan <= 1'b0;
                er_done_o <= 1'b1;
                er_hit_o <= 1'b1;
                er_addr_o <= {1'b0, er_idx};
                er_action_o <= er_act[er_idx];
            end
            // miss falls to default rule 512+n
            else if (er_idx == `TRC_ER_LAST)
            begin
                er_scan <= 1'b0;
                er_done_o <= 1'b1;
                er_hit_o <= 1'b0;
                er_addr_o <= er_daddr;
                er_action_o <= er_wrn[er_daddr] ? er_act[er_daddr] : 285'h0;
            end
            else
                er_idx <= er_idx + 9'h1;
        end
    end

endmodule // trc_tcam_core
`default_nettype wire

// file: bench/trc_tcam_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "trc_consts.vh"
module trc_tcam_core_sva (
    input wire logic clk_sys_i, // clock
    input wire logic rstn_i, // reset
    input wire logic hsel_i, // select
    input wire logic [31:0] haddr_i, // address
    input wire logic [1:0] htrans_i, // transfer
    input wire logic hwrite_i, // write
    input wire logic [31:0] hwdata_i, // wdata
    input wire logic hready_i, // bus ready
    input wire logic hreadyout_o, // slave ready
    input wire logic rp_block_en_i, // block on
    input wire logic rp_key_valid_i, // key strobe
    input wire logic rp_ready_o, // route idle
    input wire logic rp_done_o, // route done
    input wire logic rp_hit_o, // route hit
    input wire logic er_key_valid_i, // egress strobe
    input wire logic er_ready_o, // egress idle
    input wire logic [3:0] er_default_i, // default pick
    input wire logic er_done_o, // egress done
    input wire logic er_hit_o, // egress hit
    input wire logic [9:0] er_addr_o, // egress addr
    input wire logic cls_wr_o, // class copy
    input wire logic [12:0] cls_wr_addr_o, // class addr
    input wire logic busy_o // busy
);
    logic ctrl_q;
    logic [3:0] dsel_q;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);
    // Marks the data phase of a control register write
    always @(posedge clk_sys_i or negedge rstn_i)
        if (!rstn_i)
            ctrl_q <= 1'b0;
        else if (hready_i)
            ctrl_q <= hsel_i && htrans_i[1] && hwrite_i && haddr_i[11:0] == `TRC_REG_CTRL;
    // Default pick latched with the key, so a miss can be held against it
    always @(posedge clk_sys_i or negedge rstn_i)
        if (!rstn_i)
            dsel_q <= 4'h0;
        else if (er_key_valid_i && er_ready_o)
            dsel_q <= er_default_i;
    a_shot_busy: assert property (
        (ctrl_q && hready_i && hwdata_i[`TRC_CTRL_SHOT_BIT] && !busy_o) |=> busy_o)
        else $error("update command did not raise busy");
    a_busy_span: assert property (
        $rose(busy_o) |-> busy_o[*4] ##1 !busy_o)
        else $error("busy length wrong");
    a_busy_cause: assert property (
        $rose(busy_o) |-> $past(ctrl_q && hready_i && hwdata_i[`TRC_CTRL_SHOT_BIT]))
        else $error("busy rose without command");
    a_route_noblock: assert property (
        (rp_key_valid_i && rp_ready_o && !rp_block_en_i) |=> (rp_done_o && !rp_hit_o))
        else $error("route lookup without block did not miss");
    a_egr_default: assert property (
        (er_done_o && !er_hit_o) |-> er_addr_o == ((dsel_q > 4'ha) ? 10'h20a : 10'h200 + {6'h0, dsel_q}))
        else $error("egress miss address wrong");
    a_egr_hit: assert property (
        (er_done_o && er_hit_o) |-> er_addr_o < 10'h200)
        else $error("egress hit address wrong");
    a_cls_range: assert property (
        cls_wr_o |-> (cls_wr_addr_o >= `TRC_CLS_LO && cls_wr_addr_o <= `TRC_CLS_HI) ##1 !cls_wr_o)
        else $error("class copy outside range");
    a_read_wait: assert property (
        (hsel_i && hready_i && htrans_i[1] && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o)
        else $error("read wait state wrong");
    cover property (rp_done_o && rp_hit_o);
    cover property (er_done_o && !er_hit_o);
    cover property (cls_wr_o);
endmodule // trc_tcam_core_sva
`default_nettype wire

// file: bench/trc_tcam_core_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "trc_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module trc_tcam_core_test;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic rp_block_en_i = 1'b1;
    logic cls_map_i = 1'b0;
    logic rp_key_valid_i = 1'b0;
    logic er_key_valid_i = 1'b0;
    logic [34:0] rp_key_i = 35'h0;
    logic [29:0] er_key_i = 30'h0;
    logic [3:0] er_default_i = 4'h0;
    wire hreadyout_o, hresp_o, rp_ready_o, rp_done_o, rp_hit_o;
    wire er_ready_o, er_done_o, er_hit_o, cls_wr_o, busy_o;
    wire [31:0] hrdata_o;
    wire [9:0] rp_addr_o, er_addr_o;
    wire [69:0] rp_action_o;
    wire [284:0] er_action_o;
    wire [12:0] cls_wr_addr_o;
    logic [31:0] rdv;
    logic [12:0] cls_a = 13'h0;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_cls = 0;
    localparam logic [34:0] KEY_A = 35'h5_1234_5678;

    trc_tcam_core dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .rp_block_en_i(rp_block_en_i), .cls_map_i(cls_map_i), .rp_key_valid_i(rp_key_valid_i),
        .rp_key_i(rp_key_i), .rp_ready_o(rp_ready_o), .rp_done_o(rp_done_o), .rp_hit_o(rp_hit_o),
        .rp_addr_o(rp_addr_o), .rp_action_o(rp_action_o), .er_key_valid_i(er_key_valid_i),
        .er_key_i(er_key_i), .er_default_i(er_default_i), .er_ready_o(er_ready_o), .er_done_o(er_done_o),
        .er_hit_o(er_hit_o), .er_addr_o(er_addr_o), .er_action_o(er_action_o), .cls_wr_o(cls_wr_o),
        .cls_wr_addr_o(cls_wr_addr_o), .busy_o(busy_o));

    initial
    begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    task final_report;
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Sampled mid-cycle so the pulse is caught without racing the edge
    always @(negedge clk_sys_i)
    begin
        cyc++;
        if (cls_wr_o === 1'b1)
        begin
            n_cls++;
            cls_a = cls_wr_addr_o;
        end
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // Ready is looked at mid-cycle, which is the value the next edge samples
    task automatic bus_wait;
        logic r;
        do
        begin
            @(negedge clk_sys_i);
            r = hreadyout_o;
            rdv = hrdata_o;
            @(posedge clk_sys_i);
        end while (r !== 1'b1);
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        hsel_i <= 1'b1;
        haddr_i <= {20'h0, a};
        htrans_i <= 2'h2;
        hwrite_i <= w;
        bus_wait();
        htrans_i <= 2'h0;
        hwdata_i <= d;
        bus_wait();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    task automatic upd(input logic [12:0] a);
        int n;
        n = 0;
        wr(`TRC_REG_CTRL, {16'h0, a, 3'h4});
        do
        begin
            @(negedge clk_sys_i);
            if (busy_o === 1'b1)
                n++;
        end while (busy_o === 1'b1);
        repeat (2) @(posedge clk_sys_i);
        `CHK(n, `TRC_UPDATE_CYCLES)
    endtask

    task automatic look(input logic eg, input logic [34:0] k, input logic [3:0] n);
        @(posedge clk_sys_i);
        rp_key_i <= k;
        er_key_i <= k[29:0];
        er_default_i <= n;
        rp_key_valid_i <= !eg;
        er_key_valid_i <= eg;
        @(posedge clk_sys_i);
        rp_key_valid_i <= 1'b0;
        er_key_valid_i <= 1'b0;
        do @(negedge clk_sys_i); while ((eg ? er_done_o : rp_done_o) !== 1'b1);
    endtask

    task automatic rp_rule(input logic [34:0] k, input logic [12:0] a);
        // fresh rule from a cleared cache
        wr(`TRC_REG_CTRL, 32'h2);
        // code in low bit of word 0
        wr(`TRC_REG_ENTRY0, {k[30:0], `TRC_TG_X1});
        wr(`TRC_REG_ENTRY1, {28'h0, k[34:31]});
        wr(`TRC_REG_ACTION0, 32'hcafe0001);
        wr(`TRC_REG_ACTION0 + 12'h4, 32'h0bad0002);
        wr(`TRC_REG_ACTION0 + 12'h8, 32'hffffffd5);
        // masks stay zero, code always compared
        upd(a);
    endtask

    task automatic t_reset;
        @(negedge clk_sys_i);
        `CHK({busy_o, rp_ready_o, er_ready_o, hresp_o, hrdata_o}, 36'h6_0000_0000)
        wr(12'h100, 32'hffff);
        rd(12'h100);
        `CHK(rdv, 32'h0)
    endtask

    task automatic t_clear;
        logic [11:0] ca [4];
        ca = '{`TRC_REG_ENTRY0, `TRC_REG_MASK1, `TRC_REG_ACTION0, `TRC_REG_COUNTER};
        for (int i = 0; i < 4; i++)
        begin
            wr(ca[i], 32'h1);
            rd(ca[i]);
            `CHK(rdv, 32'h1)
        end
        wr(`TRC_REG_CTRL, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            rd(ca[i]);
            `CHK(rdv, 32'h0)
        end
    endtask

    task automatic t_busy;
        wr(`TRC_REG_TARGET, 32'h0);
        wr(`TRC_REG_ENTRY0, 32'h5);
        wr(`TRC_REG_CTRL, 32'h3c);
        wr(`TRC_REG_ENTRY0, 32'h9);
        @(negedge clk_sys_i);
        `CHK(busy_o, 1'b1)
        do @(negedge clk_sys_i); while (busy_o === 1'b1);
        rd(`TRC_REG_ENTRY0);
        `CHK(rdv, 32'h5)
    endtask

    task automatic t_route;
        rp_rule(KEY_A, 13'h0);
        rp_rule(KEY_A ^ 35'h6, 13'h3ff);
        for (int i = 3; i >= 0; i--)
        begin
            wr(`TRC_REG_CTRL, 32'h2);
            // X4 code 0b100 at offset 0
            // later offsets keep zero group bits
            if (i == 0)
                wr(`TRC_REG_ENTRY0, 32'h124);
            upd(13'h10 + 13'(i));
        end
        look(1'b0, 35'h92, 4'h0);
        `CHK(rp_hit_o, 1'b0)
        look(1'b0, KEY_A, 4'h0);
        `CHK({rp_hit_o, rp_addr_o}, 11'h400)
        `CHK(rp_action_o, {6'h15, 32'h0bad0002, 32'hcafe0001})
        look(1'b0, KEY_A ^ 35'h6, 4'h0);
        `CHK({rp_hit_o, rp_addr_o}, 11'h7ff)
        look(1'b0, KEY_A ^ 35'h1, 4'h0);
        `CHK(rp_hit_o, 1'b0)
        @(posedge clk_sys_i);
        rp_block_en_i <= 1'b0;
        look(1'b0, KEY_A, 4'h0);
        `CHK(rp_hit_o, 1'b0)
        @(posedge clk_sys_i);
        rp_block_en_i <= 1'b1;
    endtask

    task automatic t_range;
        logic [1:0] bt [4];
        logic [12:0] ba [4];
        int n0;
        bt = '{2'h0, 2'h1, 2'h2, 2'h2};
        ba = '{13'h400, 13'h20b, 13'hc00, 13'h400};
        n0 = n_cls;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys_i);
            cls_map_i <= (i == 2);
            wr(`TRC_REG_TARGET, {30'h0, bt[i]});
            upd(ba[i]);
            rd(`TRC_REG_STATUS);
            `CHK(rdv, 32'h2)
            wr(`TRC_REG_STATUS, 32'h2);
            rd(`TRC_REG_STATUS);
            `CHK(rdv, 32'h0)
        end
        `CHK(n_cls, n0)
    endtask

    task automatic t_egress;
        logic [287:0] ea;
        ea = 288'h0;
        wr(`TRC_REG_TARGET, 32'h1);
        wr(`TRC_REG_CTRL, 32'h2);
        wr(`TRC_REG_ENTRY0, 32'h2abcdef1);
        for (int i = 0; i < 9; i++)
        begin
            wr(`TRC_REG_ACTION0 + 12'(4 * i), 32'h11111111 * (i + 1));
            ea[32 * i +: 32] = 32'h11111111 * (i + 1);
        end
        upd(13'h5);
        look(1'b1, 35'h2abcdef1, 4'h3);
        `CHK({er_hit_o, er_addr_o}, 11'h405)
        `CHK(er_action_o, ea[284:0])
        wr(`TRC_REG_CTRL, 32'h2);
        wr(`TRC_REG_ACTION0, 32'h5a5a);
        upd(13'h203);
        for (int n = 0; n < 11; n++)
        begin
            look(1'b1, 35'h2abcdef0, 4'(n));
            `CHK({er_hit_o, er_addr_o}, 11'h200 + n)
            `CHK(er_action_o, (n == 3) ? 285'h5a5a : 285'h0)
        end
    endtask

    task automatic t_class;
        logic [12:0] ca [2];
        int n0;
        ca = '{13'h400, 13'hbff};
        @(posedge clk_sys_i);
        cls_map_i <= 1'b1;
        wr(`TRC_REG_TARGET, 32'h2);
        for (int i = 0; i < 2; i++)
        begin
            n0 = n_cls;
            upd(ca[i]);
            `CHK(n_cls, n0 + 1)
            `CHK(cls_a, ca[i])
        end
    endtask

    initial
    begin
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_reset();
        t_clear();
        t_busy();
        t_route();
        t_range();
        t_egress();
        t_class();
        final_report();
    end
endmodule // trc_tcam_core_test

bind trc_tcam_core trc_tcam_core_sva chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .rp_block_en_i(rp_block_en_i),
    .rp_key_valid_i(rp_key_valid_i), .rp_ready_o(rp_ready_o), .rp_done_o(rp_done_o),
    .rp_hit_o(rp_hit_o), .er_key_valid_i(er_key_valid_i), .er_ready_o(er_ready_o),
    .er_default_i(er_default_i), .er_done_o(er_done_o), .er_hit_o(er_hit_o), .er_addr_o(er_addr_o),
    .cls_wr_o(cls_wr_o), .cls_wr_addr_o(cls_wr_addr_o), .busy_o(busy_o));
`default_nettype wire
